// [common/p2g_pkg.sv]
// p2g_pkg: constants and carriers for the port 2 gpio / capture-compare pin block
// assumes one 200 MHz core clock and a plain strobe register port
package p2g_pkg;
   localparam int unsigned NLINES = 16;             // port width
   localparam int unsigned NFAST = 8;               // upper lines used as fast interrupts
   localparam int unsigned FAST_BASE = 8;           // first fast interrupt line
   localparam int unsigned T7_LINE = 15;            // line feeding timer seven count input
   localparam int unsigned AW = 16;                 // register address width
   // printed register offsets
   localparam logic [15:0] ADDR_ODC = 16'hF1C2;     // port2_open_drain_control
   localparam logic [15:0] ADDR_DATA = 16'hFFC0;    // port2_data_latch
   localparam logic [15:0] ADDR_DIR = 16'hFFC2;     // port2_direction
   // block-local registers
   localparam logic [15:0] ADDR_PIN = 16'hF1D0;     // pin input latch, read only
   localparam logic [15:0] ADDR_IRQ_STAT = 16'hF1D2; // sticky edge status, write one to clear
   localparam logic [15:0] ADDR_IRQ_MASK = 16'hF1D4; // interrupt enable mask
   localparam logic [15:0] RST_WORD = 16'h0000;     // reset value of every register
   // sampling figures
   localparam int unsigned CLK_MHZ = 200;           // core clock rate
   localparam int unsigned SLOW_SAMPLE_NS = 200;    // standard capture interrupt sample period
   localparam int unsigned FAST_SAMPLE_NS = 25;     // fast interrupt sample period
   localparam int unsigned SLOW_CYC = (SLOW_SAMPLE_NS * CLK_MHZ) / 1000;
   localparam int unsigned FAST_CYC = (FAST_SAMPLE_NS * CLK_MHZ) / 1000;
   // compare actions per line from the capture/compare unit
   typedef enum logic [3:0] {
      P2G_CMP_NONE = 4'h1,   // no hardware change
      P2G_CMP_TOGGLE = 4'h2, // mode 1 and double-register mode
      P2G_CMP_SET = 4'h4,    // mode 3 match
      P2G_CMP_CLEAR = 4'h8   // mode 3 timer overflow
   } p2g_cmp_e;
   // register bus request carrier
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } p2g_bus_s;
   // pin carrier: two signals per line
   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] oe_n;
   } p2g_pin_s;
endpackage : p2g_pkg

// [rtl/p2g_port.sv]
// p2g_port: sixteen-line gpio port whose lines serve the capture/compare units
// assumes pins synchronous to core_clk; bus strobes one cycle, never both at once
module p2g_port #(
   parameter int unsigned SLOW_DIV = p2g_pkg::SLOW_CYC, // slow sample period in cycles
   parameter int unsigned FAST_DIV = p2g_pkg::FAST_CYC  // fast sample period in cycles
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire p2g_pkg::p2g_bus_s bus,
   output logic [15:0] rdata,
   input wire logic [15:0] pin_in,
   output p2g_pkg::p2g_pin_s pin,
   input wire logic [15:0] cmp_trig,
   input wire p2g_pkg::p2g_cmp_e [15:0] cmp_act,
   output logic [15:0] cc_line_in,
   output logic [15:0] cc_irq_edge,
   output logic [7:0] fast_irq_edge,
   output logic timer_seven_count_input,
   output logic irq
);
   // register map seen by software (all sixteen bits wide):
   //   output latch      read/write, compare hardware may change it between writes
   //   direction         read/write, one makes the line a driven output
   //   open-drain        read/write, one lets a line drive only the low level
   //   pin input latch   read only, the level the capture unit sees
   //   edge status       sticky, write one to clear, a new edge beats the clear
   //   edge mask         read/write, gates status onto the level interrupt
   // timing seen by the rest of the chip:
   //   writes land at the edge that samples the strobe
   //   read data stand for exactly one cycle after the read strobe, zero otherwise
   //   compare actions land at the edge that samples the trigger
   //   capture lines lag the pin by one cycle, edge pulses by one cycle to one sample period more
   // limitation: edges are found by comparing samples, so a pulse shorter than
   // one sample period can be missed; that is the price of the slow sample rate
   logic [15:0] data_r;   // output latch
   logic [15:0] dir_r;    // direction
   logic [15:0] odc_r;    // open-drain control
   logic [15:0] inl_r;    // input latch
   logic [15:0] stat_r;   // sticky edge status
   logic [15:0] mask_r;   // interrupt mask
   logic [15:0] slow_smp_r; // slow-sampled levels
   logic [7:0] fast_smp_r;  // fast-sampled levels
   logic [7:0] slow_cnt_r;  // slow sample divider
   logic [7:0] fast_cnt_r;  // fast sample divider
   logic slow_tick;
   logic fast_tick;
   logic [15:0] pin_lvl;    // effective pin state
   logic [15:0] data_nxt;
   logic [15:0] slow_nxt;
   logic [7:0] fast_nxt;
   logic slow_armed_r;      // set once the slow reference sample is valid
   logic fast_armed_r;      // set once the fast reference sample is valid
   logic cpu_latch_wr;      // software write to the output latch this cycle

   // address match helper, used for every register
   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      hit = (a == r);
   endfunction : hit

   // register writes: direction and open-drain
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dir_r <= p2g_pkg::RST_WORD;
         odc_r <= p2g_pkg::RST_WORD;
      end else if (bus.wr) begin
         if (hit(bus.addr, p2g_pkg::ADDR_DIR)) begin
            dir_r <= bus.wdata;
         end else if (hit(bus.addr, p2g_pkg::ADDR_ODC)) begin
            odc_r <= bus.wdata;
         end
      end
   end

   // software write to the output latch, shared by the latch logic and its checks
   assign cpu_latch_wr = bus.wr && hit(bus.addr, p2g_pkg::ADDR_DATA);

   // per-line next output latch; software write wins over hardware trigger
   always_comb begin
      data_nxt = data_r;
      for (int i = 0; i < p2g_pkg::NLINES; i++) begin
         if (cmp_trig[i]) begin
            case (cmp_act[i])
               p2g_pkg::P2G_CMP_TOGGLE: data_nxt[i] = ~data_r[i];
               p2g_pkg::P2G_CMP_SET: data_nxt[i] = 1'b1;
               p2g_pkg::P2G_CMP_CLEAR: data_nxt[i] = 1'b0;
               default: data_nxt[i] = data_r[i];
            endcase
         end
      end
      if (cpu_latch_wr) begin
         data_nxt = bus.wdata;
      end
   end

   // output latch register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         data_r <= p2g_pkg::RST_WORD;
      end else begin
         data_r <= data_nxt;
      end
   end

   // pin drivers: enable low while driving; open-drain releases the high level
   always_comb begin
      pin.dout = data_r;
      pin.oe_n = ~(dir_r & ~(odc_r & data_r));
   end

   // effective pin level: output lines show the latch, inputs the pin
   assign pin_lvl = (dir_r & data_r) | (~dir_r & pin_in);

   // input latch, one flop of the sampled pin
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         inl_r <= p2g_pkg::RST_WORD;
      end else begin
         inl_r <= pin_lvl;
      end
   end

   // capture channel lines, one to one with port lines
   assign cc_line_in = inl_r;
   // top line doubles as timer seven count input
   assign timer_seven_count_input = inl_r[p2g_pkg::T7_LINE];

   // sample rate dividers; each makes a one-cycle tick
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slow_cnt_r <= 8'h00;
         fast_cnt_r <= 8'h00;
      end else begin
         slow_cnt_r <= slow_tick ? 8'h00 : slow_cnt_r + 8'h01;
         fast_cnt_r <= fast_tick ? 8'h00 : fast_cnt_r + 8'h01;
      end
   end
   assign slow_tick = (slow_cnt_r == 8'(SLOW_DIV - 1));
   assign fast_tick = (fast_cnt_r == 8'(FAST_DIV - 1));

   // sampled levels; edge seen when two samples differ
   assign slow_nxt = slow_tick ? inl_r : slow_smp_r;
   assign fast_nxt = fast_tick ? inl_r[p2g_pkg::FAST_BASE +: p2g_pkg::NFAST] : fast_smp_r;

   // first-tick arming: the samples reset to zero, but an idle pin may sit high behind
   // its pull-up, so the first tick after reset would report a false edge on every such
   // line; the first tick therefore only loads the reference sample
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slow_armed_r <= 1'b0;
         fast_armed_r <= 1'b0;
      end else begin
         if (slow_tick) begin
            slow_armed_r <= 1'b1; // slow reference now valid
         end
         if (fast_tick) begin
            fast_armed_r <= 1'b1; // fast reference now valid
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slow_smp_r <= p2g_pkg::RST_WORD;
         fast_smp_r <= 8'h00;
         cc_irq_edge <= p2g_pkg::RST_WORD;
         fast_irq_edge <= 8'h00;
      end else begin
         slow_smp_r <= slow_nxt;
         fast_smp_r <= fast_nxt;
         cc_irq_edge <= (slow_tick && slow_armed_r) ? (inl_r ^ slow_smp_r) : 16'h0000;
         fast_irq_edge <= (fast_tick && fast_armed_r) ?
            (inl_r[p2g_pkg::FAST_BASE +: p2g_pkg::NFAST] ^ fast_smp_r) : 8'h00;
      end
   end

   // sticky status, set wins over write-one clear; mask
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stat_r <= p2g_pkg::RST_WORD;
         mask_r <= p2g_pkg::RST_WORD;
      end else begin
         if (bus.wr && hit(bus.addr, p2g_pkg::ADDR_IRQ_STAT)) begin
            stat_r <= (stat_r & ~bus.wdata) | cc_irq_edge;
         end else begin
            stat_r <= stat_r | cc_irq_edge;
         end
         if (bus.wr && hit(bus.addr, p2g_pkg::ADDR_IRQ_MASK)) begin
            mask_r <= bus.wdata;
         end
      end
   end
   assign irq = |(stat_r & mask_r);

   // read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata <= p2g_pkg::RST_WORD;
      end else if (bus.rd) begin
         if (hit(bus.addr, p2g_pkg::ADDR_DATA)) begin
            rdata <= data_r;
         end else if (hit(bus.addr, p2g_pkg::ADDR_DIR)) begin
            rdata <= dir_r;
         end else if (hit(bus.addr, p2g_pkg::ADDR_ODC)) begin
            rdata <= odc_r;
         end else if (hit(bus.addr, p2g_pkg::ADDR_PIN)) begin
            rdata <= inl_r;
         end else if (hit(bus.addr, p2g_pkg::ADDR_IRQ_STAT)) begin
            rdata <= stat_r;
         end else if (hit(bus.addr, p2g_pkg::ADDR_IRQ_MASK)) begin
            rdata <= mask_r;
         end else begin
            rdata <= p2g_pkg::RST_WORD;
         end
      end else begin
         rdata <= p2g_pkg::RST_WORD;
      end
   end

   // checks on whole words
   // a software write to the latch lands whatever the compare unit asks
   chk_cpu_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
      cpu_latch_wr |=> data_r == $past(bus.wdata))
      else $error("cpu write lost to compare trigger");
   // with no trigger and no write the latch holds
   chk_no_trig_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      cmp_trig == 16'h0000 && !cpu_latch_wr |=> $stable(data_r))
      else $error("latch changed without trigger");
   // the top line reaches the timer seven count input
   chk_t7_route: assert property (@(posedge core_clk) disable iff (sys_rst)
      timer_seven_count_input == cc_line_in[15])
      else $error("timer seven input mismatch");
   // latch reads back what the pins are driven from
   chk_latch_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
      bus.rd && bus.addr == p2g_pkg::ADDR_DATA |=> rdata == $past(data_r))
      else $error("latch readback wrong");
   // pin input latch reads back what the capture unit sees
   chk_pin_readback: assert property (@(posedge core_clk) disable iff (sys_rst)
      bus.rd && bus.addr == p2g_pkg::ADDR_PIN |=> rdata == $past(cc_line_in))
      else $error("pin latch readback wrong");
   // read data stand only in the cycle after a read strobe
   chk_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
      !bus.rd |=> rdata == 16'h0000)
      else $error("read data outside read cycle");
   // fast edges appear only after an armed fast tick
   chk_fast_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
      fast_irq_edge != 8'h00 |-> $past(fast_tick) && $past(fast_armed_r))
      else $error("fast edge off its sample tick");
   // slow edges appear only after an armed slow tick
   chk_slow_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
      cc_irq_edge != 16'h0000 |-> $past(slow_tick) && $past(slow_armed_r))
      else $error("slow edge off its sample tick");
   // the arming tick never reports an edge
   chk_first_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(slow_armed_r) |-> cc_irq_edge == 16'h0000)
      else $error("false slow edge after reset");
   chk_fast_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(fast_armed_r) |-> fast_irq_edge == 8'h00)
      else $error("false fast edge after reset");
   // the interrupt is the level of any unmasked status bit
   chk_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
      irq == (|(stat_r & mask_r)))
      else $error("interrupt level wrong");

   // per-line checks, one copy for each port line
   for (genvar g = 0; g < p2g_pkg::NLINES; g++) begin : g_line_chk
      // mode 1 and double-register mode invert the latch
      chk_toggle_line: assert property (@(posedge core_clk) disable iff (sys_rst)
         cmp_trig[g] && cmp_act[g] == p2g_pkg::P2G_CMP_TOGGLE && !cpu_latch_wr |=> data_r[g] != $past(data_r[g]))
         else $error("toggle did not invert latch");
      // mode 3 match loads a one
      chk_set_line: assert property (@(posedge core_clk) disable iff (sys_rst)
         cmp_trig[g] && cmp_act[g] == p2g_pkg::P2G_CMP_SET && !cpu_latch_wr |=> data_r[g])
         else $error("set match missed");
      // mode 3 timer overflow loads a zero
      chk_clear_line: assert property (@(posedge core_clk) disable iff (sys_rst)
         cmp_trig[g] && cmp_act[g] == p2g_pkg::P2G_CMP_CLEAR && !cpu_latch_wr |=> !data_r[g])
         else $error("overflow clear missed");
      // an input line is never driven
      chk_drive_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
         !dir_r[g] |-> pin.oe_n[g])
         else $error("input line driven");
      // open drain never drives the high level
      chk_open_drain: assert property (@(posedge core_clk) disable iff (sys_rst)
         odc_r[g] && data_r[g] |-> pin.oe_n[g])
         else $error("open drain drove high");
      // open drain still drives the low level
      chk_od_low: assert property (@(posedge core_clk) disable iff (sys_rst)
         dir_r[g] && odc_r[g] && !data_r[g] |-> !pin.oe_n[g])
         else $error("open drain failed to drive low");
      // push-pull output always drives
      chk_push_pull: assert property (@(posedge core_clk) disable iff (sys_rst)
         dir_r[g] && !odc_r[g] |-> !pin.oe_n[g])
         else $error("push pull output released");
      // an output line shows its latch to the capture unit
      chk_capture_path: assert property (@(posedge core_clk) disable iff (sys_rst)
         dir_r[g] |=> cc_line_in[g] == $past(data_r[g]))
         else $error("output line capture mismatch");
      // an input line shows its pin to the capture unit
      chk_input_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
         !dir_r[g] |=> cc_line_in[g] == $past(pin_in[g]))
         else $error("input line capture mismatch");
      // an edge always lands in status, even beside a clear
      chk_status_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
         cc_irq_edge[g] |=> stat_r[g])
         else $error("sticky status lost");
      // status holds until software clears it
      chk_status_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
         stat_r[g] && !(bus.wr && bus.addr == p2g_pkg::ADDR_IRQ_STAT) |=> stat_r[g])
         else $error("status dropped without clear");
      // a write of one clears status when no new edge arrives
      chk_status_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
         bus.wr && bus.addr == p2g_pkg::ADDR_IRQ_STAT && bus.wdata[g] && !cc_irq_edge[g] |=> !stat_r[g])
         else $error("status clear ignored");
   end

   // main scenarios worth seeing
   cov_toggle: cover property (@(posedge core_clk)
      cmp_trig[0] && cmp_act[0] == p2g_pkg::P2G_CMP_TOGGLE);
   cov_clash: cover property (@(posedge core_clk)
      cmp_trig != 16'h0000 && bus.wr);
   cov_fast: cover property (@(posedge core_clk)
      fast_irq_edge != 8'h00);
   cov_irq: cover property (@(posedge core_clk)
      irq);
   cov_status_clear: cover property (@(posedge core_clk)
      bus.wr && bus.addr == p2g_pkg::ADDR_IRQ_STAT && stat_r != 16'h0000);
endmodule : p2g_port

// [verification/p2g_pin_model.sv]
// p2g_pin_model: board around the port pins, pull-ups plus an external driver
// assumes the bench only enables external drive on lines the port leaves released
module p2g_pin_model (
   input wire p2g_pkg::p2g_pin_s pin,
   input wire logic [15:0] ext_val,
   input wire logic [15:0] ext_en,
   output logic [15:0] pin_lvl
);
   timeunit 1ns;
   timeprecision 100ps;
   // wire level per line: port driver first, then the external source, then the pull-up
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (!pin.oe_n[i]) begin
            pin_lvl[i] = pin.dout[i]; // port drives, outside source stays off
         end else if (ext_en[i]) begin
            pin_lvl[i] = ext_val[i]; // outside source drives an input line
         end else begin
            pin_lvl[i] = 1'b1; // released: the pull-up wins, never a stale value
         end
      end
   end
endmodule : p2g_pin_model

// [verification/p2g_port_bench.sv]
// p2g_port_bench: random and corner tests of the port block
// assumes short sample dividers so that the interrupt paths settle quickly
module p2g_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   p2g_pkg::p2g_bus_s bus = '0;
   p2g_pkg::p2g_pin_s pin;
   p2g_pkg::p2g_cmp_e [15:0] cmp_act = {16{p2g_pkg::P2G_CMP_NONE}};
   logic [15:0] cmp_trig = '0, ext_val = '0, ext_en = '0, pin_lvl, rdata, cc_line_in, cc_irq_edge, got;
   logic [15:0] r, dat, dir, odc;
   logic [7:0] fast_irq_edge;
   logic t7_in, irq, seen;
   logic [31:0] seed = 32'hF3DA;
   logic [31:0] acts;
   logic [15:0] reset_addrs [6] = '{p2g_pkg::ADDR_ODC, p2g_pkg::ADDR_DATA, p2g_pkg::ADDR_DIR,
      p2g_pkg::ADDR_IRQ_STAT, p2g_pkg::ADDR_IRQ_MASK, 16'h0100};
   int miscompares = 0, total_checks = 0;
   // small dividers keep the sample ticks close; expectations only wait on them
   p2g_port #(.SLOW_DIV(4), .FAST_DIV(2)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
      .rdata(rdata), .pin_in(pin_lvl), .pin(pin), .cmp_trig(cmp_trig), .cmp_act(cmp_act),
      .cc_line_in(cc_line_in), .cc_irq_edge(cc_irq_edge), .fast_irq_edge(fast_irq_edge),
      .timer_seven_count_input(t7_in), .irq(irq));
   p2g_pin_model i_pins (.pin(pin), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_lvl));
   always #2.5 core_clk = ~core_clk;
   // next random word from the feedback register
   task automatic roll();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      r = seed[15:0];
   endtask : roll
   task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk) bus.wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge core_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk) bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   // two select bits per line: toggle, set, clear, none
   function automatic p2g_pkg::p2g_cmp_e act_of(input logic [1:0] s);
      return (s == 2'h0) ? p2g_pkg::P2G_CMP_TOGGLE : (s == 2'h1) ? p2g_pkg::P2G_CMP_SET :
         (s == 2'h2) ? p2g_pkg::P2G_CMP_CLEAR : p2g_pkg::P2G_CMP_NONE;
   endfunction : act_of
   function automatic logic [15:0] cmp_next(input logic [15:0] lat, input logic [15:0] t, input logic [31:0] s);
      for (int i = 0; i < 16; i++) begin
         if (t[i]) begin
            lat[i] = (s[2*i+:2] == 2'h0) ? ~lat[i] : (s[2*i+:2] == 2'h1) ? 1'b1 : (s[2*i+:2] == 2'h2) ? 1'b0 : lat[i];
         end
      end
      return lat;
   endfunction : cmp_next
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   // main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         rd(reset_addrs[k], got);
         check(got, 16'h0000, "reset or unmapped read");
      end
      check(pin.oe_n, 16'hFFFF, "reset enables");
      $display("test reset done");
      repeat (8) begin
         roll();
         dat = r;
         wr(p2g_pkg::ADDR_DATA, dat);
         roll();
         dir = r;
         wr(p2g_pkg::ADDR_DIR, dir);
         roll();
         odc = r;
         wr(p2g_pkg::ADDR_ODC, odc);
         roll();
         @(posedge core_clk) ext_val <= r;
         ext_en <= ~dir; // outside drive only on input lines
         rd(p2g_pkg::ADDR_DATA, got);
         check(got, dat, "latch readback");
         rd(p2g_pkg::ADDR_DIR, got);
         check(got, dir, "direction readback");
         rd(p2g_pkg::ADDR_ODC, got);
         check(got, odc, "open drain readback");
         rd(p2g_pkg::ADDR_PIN, got);
         check(got, (dir & dat) | (~dir & r), "pin latch readback");
         check(pin.oe_n, ~(dir & ~(odc & dat)), "enables");
         check(pin.dout, dat, "drive value");
         check(cc_line_in, (dir & dat) | (~dir & r), "capture input");
         check({15'h0000, t7_in}, {15'h0000, (dir[15] & dat[15]) | (~dir[15] & r[15])}, "timer input");
      end
      $display("test drive and capture done");
      ext_en <= 16'h0000;
      wr(p2g_pkg::ADDR_DIR, 16'hFFFF); // compare lines set as outputs
      repeat (12) begin
         roll();
         acts[15:0] = r;
         roll();
         acts[31:16] = r;
         roll();
         @(posedge core_clk) cmp_trig <= r;
         for (int i = 0; i < 16; i++) cmp_act[i] <= act_of(acts[2*i+:2]);
         @(posedge core_clk) cmp_trig <= 16'h0000;
         #1 dat = cmp_next(dat, r, acts);
         check(pin.dout, dat, "compare action");
      end
      roll();
      @(posedge core_clk) bus <= '{addr: p2g_pkg::ADDR_DATA, wdata: r, wr: 1'b1, rd: 1'b0};
      cmp_trig <= 16'hFFFF;
      cmp_act <= {16{p2g_pkg::P2G_CMP_TOGGLE}};
      @(posedge core_clk) bus.wr <= 1'b0;
      cmp_trig <= 16'h0000;
      #1 check(pin.dout, r, "write beats trigger");
      $display("test compare done");
      wr(p2g_pkg::ADDR_DIR, 16'h0000);
      @(posedge core_clk) ext_val <= 16'h0000;
      ext_en <= 16'hFFFF;
      repeat (20) @(posedge core_clk);
      wr(p2g_pkg::ADDR_IRQ_STAT, 16'hFFFF);
      wr(p2g_pkg::ADDR_IRQ_MASK, 16'h0008);
      @(posedge core_clk) ext_val <= 16'h0208;
      seen = 1'b0;
      for (int k = 0; k < 40 && irq !== 1'b1; k++) begin
         @(posedge core_clk);
         #1 if (fast_irq_edge[1] === 1'b1) seen = 1'b1;
      end
      if (irq !== 1'b1) begin
         miscompares++;
         $display("MISMATCH %0t interrupt wait timed out", $time);
      end
      check({15'h0000, seen}, 16'h0001, "fast edge line nine");
      rd(p2g_pkg::ADDR_IRQ_STAT, got);
      check(got, 16'h0208, "sticky status");
      wr(p2g_pkg::ADDR_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1 check({15'h0000, irq}, 16'h0000, "masked irq");
      wr(p2g_pkg::ADDR_IRQ_STAT, 16'h0208);
      rd(p2g_pkg::ADDR_IRQ_STAT, got);
      check(got, 16'h0000, "status cleared");
      $display("test interrupt done");
      complete_run();
   end
endmodule : p2g_port_bench
